// file: fwp_write_protect.sv
// Write-protection and status logic of a serial NOR flash, facing the SPI pins
`timescale 1ns/100ps
module fwp_write_protect #(
    parameter int PUW_CYCLES_P = fwp_pkg::PUW_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic mosi_i,
    input wire logic wp_n_i,
    input wire logic op_done_i,
    output logic miso_o,
    output logic miso_oe_o,
    output logic [7:0] status_register_o,
    output logic deep_sleep_state_o,
    output logic cmd_valid_o,
    output logic [7:0] cmd_opcode_o,
    output logic [23:0] cmd_addr_o,
    output logic protect_reject_o
);
    import fwp_pkg::*;

    fwp_state_t st;
    fwp_state_t next_st;

    localparam logic [PUW_W-1:0] PUW_LAST = PUW_W'(PUW_CYCLES_P - 1);

    // Upper protected address for a protect code; none for code zero
    function automatic logic [18:0] range_limit(input logic [2:0] level);
        logic [18:0] lim;
        lim = '0;
        unique case (level)
            3'h0: lim = '0;
            3'h1: lim = LIM_001;
            3'h2: lim = LIM_010;
            3'h3: lim = LIM_011;
            3'h4: lim = LIM_100;
            3'h5: lim = LIM_101;
            3'h6: lim = LIM_110;
            3'h7: lim = LIM_111;
        endcase
        return lim;
    endfunction

    // Whether the first byte of the target region lies in a protected range
    function automatic logic is_protected(input logic [2:0] level, input logic [7:0] op,
                                          input logic [23:0] addr);
        logic [18:0] start;
        start = addr[18:0];
        if (op == OP_SECTOR_ERASE) begin
            start = {addr[18:12], 12'h000};
        end else if (op == OP_HALF_BLOCK_ERASE) begin
            start = {addr[18:15], 15'h0000};
        end else if (op == OP_BLOCK_ERASE) begin
            start = {addr[18:16], 16'h0000};
        end else if (op == OP_CHIP_ERASE_A || op == OP_CHIP_ERASE_B) begin
            start = '0;
        end
        return (level != 3'h0) && (start <= range_limit(level));
    endfunction

    // Status register image: lock, two reserved zeros, protect level, latch, busy
    function automatic logic [7:0] status_image(input fwp_state_t s);
        logic [7:0] img;
        img = 8'h00;
        img[SR_LOCK] = s.status_lock_bit;
        img[SR_BP_HI:SR_BP_LO] = s.protect_level;
        img[SR_WEL] = s.write_enable_latch;
        img[SR_BUSY] = s.busy;
        return img;
    endfunction

    logic sclk_rise;
    logic sclk_fall;
    logic frame_end;
    logic in_frame;
    logic byte_aligned;
    logic write_ready;
    logic is_prog_erase;
    logic hw_locked;
    logic [7:0] sr_now;

    always_comb begin
        sclk_rise = st.clk_s2 & ~st.clk_d;
        sclk_fall = ~st.clk_s2 & st.clk_d;
        in_frame = ~st.cs_s2 & ~st.cs_d;
        frame_end = st.cs_s2 & ~st.cs_d;
        byte_aligned = (st.nbits[2:0] == 3'h0) && (st.nbits >= LEN_OPCODE);
        write_ready = st.puw_done & st.write_enable_latch;
        hw_locked = st.status_lock_bit & ~st.wp_s2;
        sr_now = status_image(st);
        is_prog_erase = 1'b0;
        unique case (st.opcode)
            OP_PAGE_PROG, OP_SECTOR_ERASE, OP_HALF_BLOCK_ERASE, OP_BLOCK_ERASE,
            OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: is_prog_erase = 1'b1;
            default: is_prog_erase = 1'b0;
        endcase

        next_st = st;
        next_st.cmd_valid = 1'b0;
        next_st.protect_reject = 1'b0;

        // Pin synchronisers
        next_st.cs_s1 = cs_n_i;
        next_st.cs_s2 = st.cs_s1;
        next_st.cs_d = st.cs_s2;
        next_st.clk_s1 = sclk_i;
        next_st.clk_s2 = st.clk_s1;
        next_st.clk_d = st.clk_s2;
        next_st.di_s1 = mosi_i;
        next_st.di_s2 = st.di_s1;
        next_st.wp_s1 = wp_n_i;
        next_st.wp_s2 = st.wp_s1;

        // Power-up write lockout
        if (!st.puw_done) begin
            if (st.puw_cnt == PUW_LAST) begin
                next_st.puw_done = 1'b1;
            end else begin
                next_st.puw_cnt = st.puw_cnt + 1'b1;
            end
        end

        // End of an internal cycle
        if (st.busy && op_done_i) begin
            next_st.busy = 1'b0;
        end

        // Bit shifting on rising clock edges within a frame
        if (st.cs_s2) begin
            next_st.nbits = '0;
            next_st.miso_oe = 1'b0;
        end else if (in_frame && sclk_rise) begin
            if (st.nbits != '1) begin
                next_st.nbits = st.nbits + 1'b1;
            end
            if (st.nbits < LEN_OPCODE) begin
                next_st.opcode = {st.opcode[6:0], st.di_s2};
            end else if (st.nbits < LEN_ADDR) begin
                next_st.addr = {st.addr[22:0], st.di_s2};
            end
            if (st.nbits >= LEN_OPCODE && st.nbits < LEN_STATUS) begin
                next_st.wdata = {st.wdata[6:0], st.di_s2};
            end
        end

        // Status read data out on falling clock edges, served even while busy
        if (in_frame && sclk_fall && st.nbits >= LEN_OPCODE && !st.deep_sleep_state &&
            st.opcode == OP_STATUS_READ) begin
            next_st.miso_oe = 1'b1;
            next_st.miso = sr_now[3'h7 - st.nbits[2:0]];
        end

        // Command execution at chip select release
        if (frame_end) begin
            if (st.deep_sleep_state) begin
                if (st.opcode == OP_SLEEP_RELEASE && st.nbits >= LEN_OPCODE) begin
                    next_st.deep_sleep_state = 1'b0;
                end
            end else if (st.busy) begin
                next_st.busy = st.busy;
            end else if (byte_aligned) begin
                if (st.opcode == OP_WR_ENABLE) begin
                    if (st.puw_done) begin
                        next_st.write_enable_latch = 1'b1;
                    end
                end else if (st.opcode == OP_WR_DISABLE) begin
                    next_st.write_enable_latch = 1'b0;
                end else if (st.opcode == OP_SLEEP_ENTER) begin
                    next_st.deep_sleep_state = 1'b1;
                end else if (st.opcode == OP_STATUS_WRITE) begin
                    // Only non-volatile bits change; busy is the cycle, latch clears as it starts
                    if (write_ready && !hw_locked && st.nbits >= LEN_STATUS) begin
                        next_st.status_lock_bit = st.wdata[SR_LOCK];
                        next_st.protect_level = st.wdata[SR_BP_HI:SR_BP_LO];
                        next_st.write_enable_latch = 1'b0;
                        next_st.busy = 1'b1;
                        next_st.cmd_valid = 1'b1;
                        next_st.cmd_opcode = st.opcode;
                        next_st.cmd_addr = '0;
                    end
                end else if (is_prog_erase && write_ready) begin
                    if ((st.opcode == OP_CHIP_ERASE_A || st.opcode == OP_CHIP_ERASE_B ||
                         (st.opcode == OP_PAGE_PROG && st.nbits >= LEN_PROG) ||
                         (st.opcode != OP_PAGE_PROG && st.nbits >= LEN_ADDR))) begin
                        if (is_protected(st.protect_level, st.opcode, st.addr)) begin
                            next_st.protect_reject = 1'b1;
                        end else begin
                            next_st.write_enable_latch = 1'b0;
                            next_st.busy = 1'b1;
                            next_st.cmd_valid = 1'b1;
                            next_st.cmd_opcode = st.opcode;
                            next_st.cmd_addr = st.addr;
                        end
                    end
                end
            end
        end
    end

    // All state cleared, chip select and write-protect synchronisers set high, while the supply is below threshold
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
            st.cs_s1 <= 1'b1;
            st.cs_s2 <= 1'b1;
            st.cs_d <= 1'b1;
            st.wp_s1 <= 1'b1;
            st.wp_s2 <= 1'b1;
            st.write_enable_latch <= 1'b0;
            st.protect_level <= BP_RESET;
            st.status_lock_bit <= LOCK_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign miso_o = st.miso;
    assign miso_oe_o = st.miso_oe;
    assign status_register_o = sr_now;
    assign deep_sleep_state_o = st.deep_sleep_state;
    assign cmd_valid_o = st.cmd_valid;
    assign cmd_opcode_o = st.cmd_opcode;
    assign cmd_addr_o = st.cmd_addr;
    assign protect_reject_o = st.protect_reject;
endmodule

// file: fwp_pkg.sv
// Constants, opcodes and state layout for the flash write-protect logic
package fwp_pkg;
    // Core clock rate and power-up write lockout
    localparam int CLK_MHZ = 10;
    localparam int PUW_DELAY_US = 1000;
    localparam int PUW_CYCLES = PUW_DELAY_US * CLK_MHZ;
    localparam int PUW_W = 24;
    localparam int NBITS_W = 16;

    // Instruction codes
    localparam logic [7:0] OP_WR_ENABLE = 8'h06;
    localparam logic [7:0] OP_WR_DISABLE = 8'h04;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_PAGE_PROG = 8'h02;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] OP_HALF_BLOCK_ERASE = 8'h52;
    localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'hc7;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
    localparam logic [7:0] OP_SLEEP_ENTER = 8'hb9;
    localparam logic [7:0] OP_SLEEP_RELEASE = 8'hab;

    // Status register bit positions
    localparam int SR_BUSY = 0;
    localparam int SR_WEL = 1;
    localparam int SR_BP_LO = 2;
    localparam int SR_BP_HI = 4;
    localparam int SR_LOCK = 7;

    // Reset values of the status bits
    localparam logic [2:0] BP_RESET = 3'h0;
    localparam logic LOCK_RESET = 1'b0;

    // Least frame lengths in bits
    localparam logic [NBITS_W-1:0] LEN_OPCODE = 16'h0008;
    localparam logic [NBITS_W-1:0] LEN_STATUS = 16'h0010;
    localparam logic [NBITS_W-1:0] LEN_ADDR = 16'h0020;
    localparam logic [NBITS_W-1:0] LEN_PROG = 16'h0028;

    // Upper bounds of protected ranges, each starting at zero
    localparam logic [18:0] LIM_001 = 19'h7dfff;
    localparam logic [18:0] LIM_010 = 19'h7bfff;
    localparam logic [18:0] LIM_011 = 19'h77fff;
    localparam logic [18:0] LIM_100 = 19'h6ffff;
    localparam logic [18:0] LIM_101 = 19'h5ffff;
    localparam logic [18:0] LIM_110 = 19'h3ffff;
    localparam logic [18:0] LIM_111 = 19'h7ffff;

    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic cs_d;
        logic clk_s1;
        logic clk_s2;
        logic clk_d;
        logic di_s1;
        logic di_s2;
        logic wp_s1;
        logic wp_s2;
        logic [7:0] opcode;
        logic [23:0] addr;
        logic [7:0] wdata;
        logic [NBITS_W-1:0] nbits;
        logic [PUW_W-1:0] puw_cnt;
        logic puw_done;
        logic write_enable_latch;
        logic busy;
        logic deep_sleep_state;
        logic status_lock_bit;
        logic [2:0] protect_level;
        logic miso;
        logic miso_oe;
        logic cmd_valid;
        logic [7:0] cmd_opcode;
        logic [23:0] cmd_addr;
        logic protect_reject;
    } fwp_state_t;
endpackage

// file: fwp_monitor.sv
// Checker of the write-protect block's port behaviour
`timescale 1ns/100ps
module fwp_monitor (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic op_done_i,
    input wire logic [7:0] status_register_o,
    input wire logic deep_sleep_state_o,
    input wire logic cmd_valid_o,
    input wire logic protect_reject_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    property p_v_busy; cmd_valid_o |-> status_register_o[0]; endproperty
    a_v_busy: assert property (p_v_busy) else $error("busy not set");
    property p_v_wel; cmd_valid_o |-> !status_register_o[1] && $past(status_register_o[1]); endproperty
    a_v_wel: assert property (p_v_wel) else $error("latch misuse");
    property p_r_busy; protect_reject_o |-> !status_register_o[0] && !cmd_valid_o; endproperty
    a_r_busy: assert property (p_r_busy) else $error("refused but busy");
    property p_r_wel; protect_reject_o |-> status_register_o[1]; endproperty
    a_r_wel: assert property (p_r_wel) else $error("refused without latch");
    property p_done; op_done_i |=> !status_register_o[0]; endproperty
    a_done: assert property (p_done) else $error("busy not cleared");
    property p_hold; status_register_o[0] && !op_done_i |=> status_register_o[0]; endproperty
    a_hold: assert property (p_hold) else $error("busy dropped early");
    property p_sleep; deep_sleep_state_o |-> !cmd_valid_o && !protect_reject_o; endproperty
    a_sleep: assert property (p_sleep) else $error("command while asleep");
    property p_resv; status_register_o[6:5] == 2'h0; endproperty
    a_resv: assert property (p_resv) else $error("reserved bits set");
endmodule

// file: fwp_spi_host.sv
// SPI host model that frames commands toward the flash
`timescale 1ns/100ps
module fwp_spi_host (
    input wire logic core_clk_i,
    input wire logic miso_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic mosi_o
);
    logic [39:0] rx;
    initial begin
        rx = '0;
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        mosi_o = 1'b1;
    end
    // Mode 0 frame, MSB first; the clock stands low between frames
    task automatic send(input logic [39:0] v, input int n);
        @(negedge core_clk_i);
        cs_n_o = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            mosi_o = v[i];
            repeat (4) @(negedge core_clk_i);
            // Read data taken just before the rising clock edge
            rx = {rx[38:0], miso_i};
            sclk_o = 1'b1;
            repeat (4) @(negedge core_clk_i);
            sclk_o = 1'b0;
        end
        repeat (2) @(negedge core_clk_i);
        cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
        repeat (8) @(negedge core_clk_i);
    endtask
endmodule

// file: fwp_write_protect_tb.sv
// Testbench of the flash write-protect block
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
    $display("wrong value at %0t: %h %h", $time, (a), (b)); end end
module fwp_write_protect_tb;
    import fwp_pkg::*;
    localparam int PUW = 400;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wp_n_i = 1'b1;
    logic op_done_i = 1'b0;
    wire logic cs_n, sclk, mosi;
    logic miso, oe, sleep, vld, rej;
    logic [7:0] sr, op;
    logic [23:0] ad;
    int mismatches = 0, n_tests = 0, cycles = 0, nv = 0, nr = 0, ev = 0, er = 0, noe = 0;
    fwp_write_protect #(.PUW_CYCLES_P(PUW)) dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .cs_n_i(cs_n), .sclk_i(sclk), .mosi_i(mosi), .wp_n_i(wp_n_i), .op_done_i(op_done_i),
        .miso_o(miso), .miso_oe_o(oe), .status_register_o(sr), .deep_sleep_state_o(sleep),
        .cmd_valid_o(vld), .cmd_opcode_o(op), .cmd_addr_o(ad), .protect_reject_o(rej));
    fwp_spi_host host (.core_clk_i(core_clk_i), .miso_i(miso), .cs_n_o(cs_n), .sclk_o(sclk),
        .mosi_o(mosi));
    initial forever #50 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        cycles++;
        if (vld === 1'b1) nv++;
        if (rej === 1'b1) nr++;
        if (oe === 1'b1) noe++;
        if (cycles == 20000) begin
            mismatches++;
            complete_run;
        end
    end
    task automatic done;
        @(negedge core_clk_i) op_done_i = 1'b1;
        @(negedge core_clk_i) op_done_i = 1'b0;
        @(negedge core_clk_i);
        `CHK(sr[0], 1'b0)
    endtask
    task automatic wstat(input logic [7:0] d);
        host.send(40'h06, 8);
        host.send({24'h0, OP_STATUS_WRITE, d}, 16);
    endtask
    task automatic prog(input logic [23:0] a);
        host.send(40'h06, 8);
        host.send({OP_PAGE_PROG, a, 8'h5a}, 40);
    endtask
    task automatic t_powerup;
        `CHK(sr, 8'h00)
        host.send(40'h06, 8);
        `CHK(sr[1], 1'b0)
        repeat (PUW) @(negedge core_clk_i);
    endtask
    task automatic t_latch;
        host.send(40'h0c, 9);
        `CHK(sr[1], 1'b0)
        host.send(40'h06, 8);
        `CHK(sr[1], 1'b1)
        host.send(40'h04, 8);
        `CHK(sr[1], 1'b0)
        host.send({OP_PAGE_PROG, 32'h0000005a}, 40);
        `CHK(nv, ev)
        host.send(40'h06, 8);
        host.send({OP_SECTOR_ERASE, 24'h001000, 1'b0}, 33);
        `CHK(nv, ev)
    endtask
    task automatic t_status;
        wstat(8'h9f);
        ev++;
        `CHK(nv, ev)
        `CHK(op, OP_STATUS_WRITE)
        `CHK(sr, 8'h9d)
        host.send({OP_STATUS_READ, 8'h00}, 16);
        `CHK(host.rx[7:0], 8'h9d)
        `CHK(noe > 0, 1'b1)
        `CHK(oe, 1'b0)
        done;
        wp_n_i = 1'b0;
        wstat(8'h00);
        `CHK(sr, 8'h9e)
        wp_n_i = 1'b1;
        wstat(8'h00);
        ev++;
        done;
        `CHK(sr, 8'h00)
    endtask
    task automatic t_ranges;
        logic [18:0] lims [1:7] = '{19'h7dfff, 19'h7bfff, 19'h77fff, 19'h6ffff,
            19'h5ffff, 19'h3ffff, 19'h7ffff};
        for (int c = 1; c <= 7; c++) begin
            wstat({3'h0, c[2:0], 2'h0});
            ev++;
            done;
            prog({5'h0, lims[c]});
            er++;
            `CHK(nr, er)
            `CHK(sr[1:0], 2'h2)
            if (c == 1) begin
                host.send({OP_BLOCK_ERASE, 24'h07e000}, 32);
                er++;
                `CHK(nr, er)
            end
            prog({5'h0, lims[c] + 19'h1});
            if (c == 7) er++;
            else ev++;
            `CHK(nv, ev)
            `CHK(nr, er)
            if (c != 7) `CHK(ad, {5'h0, lims[c] + 19'h1})
            if (c != 7) done;
        end
        host.send({32'h0, OP_CHIP_ERASE_A}, 8);
        er++;
        `CHK(nr, er)
    endtask
    task automatic t_sleep;
        wstat(8'h00);
        ev++;
        done;
        prog(24'h000100);
        ev++;
        `CHK(nv, ev)
        host.send(40'h06, 8);
        `CHK(sr, 8'h01)
        done;
        host.send(40'hb9, 8);
        `CHK(sleep, 1'b1)
        host.send(40'h06, 8);
        `CHK(sr[1], 1'b0)
        host.send({OP_SLEEP_RELEASE, 24'h0}, 32);
        `CHK(sleep, 1'b0)
        host.send(40'h06, 8);
        `CHK(sr[1], 1'b1)
        rst_i = 1'b1;
        host.send(40'h06, 8);
        rst_i = 1'b0;
        repeat (4) @(negedge core_clk_i);
        `CHK(sr, 8'h00)
        host.send(40'h06, 8);
        `CHK(sr[1], 1'b0)
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge core_clk_i);
        rst_i = 1'b0;
        t_powerup;
        t_latch;
        t_status;
        t_ranges;
        t_sleep;
        complete_run;
    end
endmodule
bind fwp_write_protect fwp_monitor mon (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .op_done_i(op_done_i), .status_register_o(status_register_o),
    .deep_sleep_state_o(deep_sleep_state_o), .cmd_valid_o(cmd_valid_o),
    .protect_reject_o(protect_reject_o));
